// file: inc/rtcr_pkg.sv
// constants for the rtc rate trim and temperature compensation block
package rtcr_pkg;
   // register indices; byte address is four times the index
   localparam logic [13:0] IDX_TEMP_HIGH = 14'h2881;
   localparam logic [13:0] IDX_TEMP_LOW = 14'h2882;
   localparam logic [13:0] IDX_TABLE_INDEX_CTRL = 14'h2887;
   localparam logic [13:0] IDX_TABLE_BYTE = 14'h2888;
   localparam logic [13:0] IDX_TABLE_STROBES = 14'h2889;
   localparam logic [13:0] IDX_SHADOW_CTRL = 14'h2890;
   localparam logic [13:0] IDX_RATE_COARSE_TOP = 14'h289B;
   localparam logic [13:0] IDX_RATE_COARSE_MID = 14'h289C;
   localparam logic [13:0] IDX_RATE_COARSE_LOW_FINE = 14'h289D;
   localparam logic [13:0] IDX_AUTO_COMP_ENABLE = 14'h28A0;
   localparam logic [13:0] IDX_TEST_MUX_SEL = 14'h28A1;
   localparam logic [13:0] IDX_CRYSTAL_LOAD_TRIM = 14'h2504;

   // field positions
   localparam int AUTOINC_BIT = 7;
   localparam int RD_STROBE_BIT = 1;
   localparam int WR_STROBE_BIT = 0;
   localparam int HOLD_BIT = 7;
   localparam int COMP_EN_BIT = 5;
   localparam int TEMP_LOW_LSB = 5;

   // widths
   localparam int COARSE_W = 17;
   localparam int FINE_W = 2;
   localparam int PERIOD_W = 19;
   localparam int TEMP_W = 11;
   localparam int TABLE_AW = 7;
   localparam int TABLE_DEPTH = 128;
   localparam int TRIM_W = 7;

   // reset values
   localparam logic [COARSE_W-1:0] COARSE_RESET = 17'h10000;
   localparam logic [FINE_W-1:0] FINE_RESET = 2'h0;
   localparam logic [TRIM_W-1:0] TRIM_RESET = 7'h40;
   localparam logic [PERIOD_W-1:0] PERIOD_NOMINAL = 19'h40000;

   // index saturation limits after the shift by two
   localparam logic signed [8:0] INDEX_MAX = 9'sh03F;
   localparam logic signed [8:0] INDEX_MIN = -9'sh040;

   // one crystal tick counts eight eighths
   localparam logic [19:0] EIGHTHS_PER_TICK = 20'h00008;
   // crystal ticks per slow shadow-transfer tick (about 500 Hz)
   localparam logic [5:0] SLOW_TICK_LAST = 6'h3F;

   // test mux selections
   localparam logic [1:0] TMUX_OFF = 2'h0;
   localparam logic [1:0] TMUX_ONE_SECOND_TEST_PULSE = 2'h1;
   localparam logic [1:0] TMUX_FOUR_SECOND_TEST_PULSE = 2'h2;
endpackage

// file: rtl/rtcr_second_gen.sv
// second boundary generator with rate dither and test pulses
`timescale 1ns/100ps
module rtcr_second_gen
   import rtcr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic crystal_tick_i,
   input wire logic [PERIOD_W-1:0] period_i,
   output logic second_o,
   output logic one_second_test_pulse_o,
   output logic four_second_test_pulse_o
);
   typedef struct packed {
      logic [19:0] acc;
      logic [PERIOD_W-1:0] period;
      logic [1:0] sec_cnt;
      logic second;
      logic p1;
      logic p4;
   } rtcr_sg_s;

   localparam rtcr_sg_s SG_RESET = '{acc: '0, period: PERIOD_NOMINAL, sec_cnt: '0,
                                     second: 1'b0, p1: 1'b0, p4: 1'b0};

   rtcr_sg_s r, n;
   logic [19:0] acc_plus;

   always_comb begin
      n = r;
      n.second = 1'b0;
      acc_plus = r.acc + EIGHTHS_PER_TICK;
      if (crystal_tick_i) begin
         // span of a second in eighths of a tick; fine bits dither it
         if (acc_plus >= {1'b0, r.period}) begin
            n.acc = acc_plus - {1'b0, r.period};
            n.second = 1'b1;
            n.sec_cnt = r.sec_cnt + 2'h1;
            // new rate only at a second boundary
            n.period = period_i;
         end else begin
            n.acc = acc_plus;
         end
      end
      // quarter-period high test waveforms
      n.p1 = n.acc < {3'h0, r.period[PERIOD_W-1:2]};
      n.p4 = n.sec_cnt == 2'h0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= SG_RESET;
      end else begin
         r <= n;
      end
   end

   assign second_o = r.second;
   assign one_second_test_pulse_o = r.p1;
   assign four_second_test_pulse_o = r.p4;
endmodule

// file: rtl/rtcr_rate_comp.sv
// rtc rate control, shadow transfer, lookup table and temperature compensation
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
module rtcr_rate_comp
   import rtcr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic crystal_tick_i,
   input wire logic [TEMP_W-1:0] die_temperature_result_i,
   input wire logic temp_done_i,
   input wire logic sleep_mode_i,
   output logic [TRIM_W-1:0] crystal_load_trim_o,
   output logic second_tick_o,
   output logic test_mux_output_o
);
   typedef enum {ST_IDLE, ST_SW_RD, ST_COMP_LOAD} rtcr_state_e;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [TRIM_W-1:0] trim;
      logic autoinc;
      logic [TABLE_AW-1:0] tindex;
      logic [7:0] tbyte;
      logic rd_stb;
      logic wr_stb;
      logic hold;
      logic pending;
      logic [COARSE_W-1:0] sh_p;
      logic [FINE_W-1:0] sh_q;
      logic [2:0] chg;
      logic [COARSE_W-1:0] live_p;
      logic [FINE_W-1:0] live_q;
      logic comp_en;
      logic comp_req;
      logic [1:0] tmux_sel;
      logic tmux;
      logic [5:0] slow_cnt;
      logic [TEMP_W-1:0] temp;
      rtcr_state_e st;
   } rtcr_rc_s;

   localparam rtcr_rc_s RC_RESET = '{ack: 1'b0, rdata: '0, trim: TRIM_RESET, autoinc: 1'b0, tindex: '0,
                                     tbyte: '0, rd_stb: 1'b0, wr_stb: 1'b0, hold: 1'b0, pending: 1'b0,
                                     sh_p: COARSE_RESET, sh_q: FINE_RESET, chg: '0,
                                     live_p: COARSE_RESET, live_q: FINE_RESET, comp_en: 1'b0,
                                     comp_req: 1'b0, tmux_sel: TMUX_OFF, tmux: 1'b0, slow_cnt: '0,
                                     temp: '0, st: ST_IDLE};

   rtcr_rc_s r, n;
   logic [7:0] table_mem [TABLE_DEPTH];
   logic [7:0] mem_q;
   logic [TABLE_AW-1:0] mem_addr;
   logic mem_we;
   logic sec_pulse, one_second_test_pulse, four_second_test_pulse;
   logic [PERIOD_W-1:0] comp_sum;
   logic req, wr_now;
   logic [13:0] idx;
   logic [7:0] wbyte;

   // register index from a byte address
   function automatic logic [13:0] reg_index(input logic [15:0] adr);
      return adr[15:2];
   endfunction

   // temperature to table address, shifted and saturated
   function automatic logic [TABLE_AW-1:0] temp_to_index(input logic [TEMP_W-1:0] t);
      logic signed [8:0] s;
      s = 9'(signed'(t) >>> 2);
      if (s > INDEX_MAX) begin
         s = INDEX_MAX;
      end else if (s < INDEX_MIN) begin
         s = INDEX_MIN;
      end
      return s[TABLE_AW-1:0];
   endfunction

   // read data for one register index
   function automatic logic [7:0] read_reg(input logic [13:0] i, input rtcr_rc_s s);
      case (i)
         IDX_TEMP_HIGH: return s.temp[TEMP_W-1:3];
         IDX_TEMP_LOW: return {s.temp[2:0], 5'h00};
         IDX_TABLE_INDEX_CTRL: return {s.autoinc, s.tindex};
         IDX_TABLE_BYTE: return s.tbyte;
         IDX_TABLE_STROBES: return {6'h00, s.rd_stb, s.wr_stb};
         IDX_SHADOW_CTRL: return {s.hold | s.pending, 7'h00};
         IDX_RATE_COARSE_TOP: return {5'h00, s.sh_p[16:14]};
         IDX_RATE_COARSE_MID: return s.sh_p[13:6];
         IDX_RATE_COARSE_LOW_FINE: return {s.sh_p[5:0], s.sh_q};
         IDX_AUTO_COMP_ENABLE: return {2'h0, s.comp_en, 5'h00};
         IDX_TEST_MUX_SEL: return {6'h00, s.tmux_sel};
         IDX_CRYSTAL_LOAD_TRIM: return {1'b0, s.trim};
         default: return 8'h00;
      endcase
   endfunction

   // sign-extended table entry added to the nominal period
   assign comp_sum = PERIOD_NOMINAL + {{(PERIOD_W-8){mem_q[7]}}, mem_q};

   always_comb begin
      n = r;
      mem_we = 1'b0;
      mem_addr = r.tindex;
      req = wb_cyc_i && wb_stb_i;
      wr_now = req && wb_we_i && r.ack && wb_sel_i[0];
      idx = reg_index(wb_adr_i);
      wbyte = wb_dat_i[7:0];

      // single-cycle wishbone answer, data latched with ack
      n.ack = req && !r.ack;
      if (req && !r.ack) begin
         n.rdata = {24'h000000, read_reg(idx, r)};
      end

      // a request left over from an earlier enable must not fire later
      if (!r.comp_en) begin
         n.comp_req = 1'b0;
      end
      // capture each measurement; flag a compensation pass
      if (temp_done_i) begin
         n.temp = die_temperature_result_i;
         if (r.comp_en) begin
            n.comp_req = 1'b1;
         end
      end

      // table access engine; compensation served first
      case (r.st)
         ST_IDLE: begin
            if (r.comp_req && r.comp_en) begin
               mem_addr = temp_to_index(r.temp);
               n.comp_req = temp_done_i && r.comp_en;
               n.st = ST_COMP_LOAD;
            end else if (r.wr_stb) begin
               mem_we = 1'b1;
               n.wr_stb = 1'b0;
               if (r.autoinc) begin
                  n.tindex = r.tindex + 7'h01;
               end
            end else if (r.rd_stb) begin
               n.st = ST_SW_RD;
            end
         end
         ST_SW_RD: begin
            n.tbyte = mem_q;
            n.rd_stb = 1'b0;
            if (r.autoinc) begin
               n.tindex = r.tindex + 7'h01;
            end
            n.st = ST_IDLE;
         end
         ST_COMP_LOAD: begin
            // reload only while enabled; otherwise periods untouched
            if (r.comp_en) begin
               n.live_p = comp_sum[PERIOD_W-1:FINE_W];
               n.live_q = comp_sum[FINE_W-1:0];
            end
            n.st = ST_IDLE;
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase
      if (r.st == ST_IDLE && !(r.comp_req && r.comp_en) && !r.wr_stb && r.rd_stb) begin
         mem_addr = r.tindex;
      end

      // slow tick derived from the crystal tick
      if (crystal_tick_i) begin
         n.slow_cnt = r.slow_cnt + 6'h01;
      end
      // changed words move to the live rate on the slow tick
      // placed before the register writes so a same-cycle rate write sets chg again and a hold release sets pending again
      if (crystal_tick_i && r.slow_cnt == SLOW_TICK_LAST && r.pending) begin
         if (r.chg[2]) begin
            n.live_p[16:14] = r.sh_p[16:14];
         end
         if (r.chg[1]) begin
            n.live_p[13:6] = r.sh_p[13:6];
         end
         if (r.chg[0]) begin
            n.live_p[5:0] = r.sh_p[5:0];
            n.live_q = r.sh_q;
         end
         n.chg = '0;
         n.pending = 1'b0; // hold reads one until here
      end

      // shadow follows the live rate unless held
      if (!r.hold && !r.pending) begin
         n.sh_p = n.live_p;
         n.sh_q = n.live_q;
      end

      // register writes take effect at the acked edge
      if (wr_now) begin
         case (idx)
            IDX_TABLE_INDEX_CTRL: begin
               n.autoinc = wbyte[AUTOINC_BIT];
               n.tindex = wbyte[TABLE_AW-1:0];
            end
            IDX_TABLE_BYTE: n.tbyte = wbyte;
            IDX_TABLE_STROBES: begin
               // writing one starts an access; zero does not cancel
               n.rd_stb = n.rd_stb | wbyte[RD_STROBE_BIT];
               n.wr_stb = n.wr_stb | wbyte[WR_STROBE_BIT];
            end
            IDX_SHADOW_CTRL: begin
               n.hold = wbyte[HOLD_BIT];
               if (r.hold && !wbyte[HOLD_BIT]) begin
                  n.pending = 1'b1;
               end
            end
            IDX_RATE_COARSE_TOP: begin
               n.sh_p[16:14] = wbyte[2:0];
               n.chg[2] = 1'b1;
            end
            IDX_RATE_COARSE_MID: begin
               n.sh_p[13:6] = wbyte;
               n.chg[1] = 1'b1;
            end
            IDX_RATE_COARSE_LOW_FINE: begin
               n.sh_p[5:0] = wbyte[7:2];
               n.sh_q = wbyte[1:0];
               n.chg[0] = 1'b1;
            end
            IDX_AUTO_COMP_ENABLE: n.comp_en = wbyte[COMP_EN_BIT];
            IDX_TEST_MUX_SEL: n.tmux_sel = wbyte[1:0];
            IDX_CRYSTAL_LOAD_TRIM: n.trim = wbyte[TRIM_W-1:0];
            default: begin
            end
         endcase
      end

      // test output selection
      case (r.tmux_sel)
         TMUX_ONE_SECOND_TEST_PULSE: n.tmux = one_second_test_pulse;
         TMUX_FOUR_SECOND_TEST_PULSE: n.tmux = four_second_test_pulse;
         default: n.tmux = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= RC_RESET;
      end else begin
         r <= n;
      end
   end

   // battery-backed table; contents survive reset
   always_ff @(posedge clk_i) begin
      if (mem_we) begin
         table_mem[r.tindex] <= r.tbyte;
      end
      mem_q <= table_mem[mem_addr];
   end

   // period is four coarse plus fine eighths
   rtcr_second_gen u_second_gen (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .crystal_tick_i(crystal_tick_i),
      .period_i({r.live_p, r.live_q}),
      .second_o(sec_pulse),
      .one_second_test_pulse_o(one_second_test_pulse),
      .four_second_test_pulse_o(four_second_test_pulse)
   );

   assign wb_ack_o = r.ack;
   assign wb_dat_o = r.rdata;
   assign crystal_load_trim_o = r.trim; // zero least load, all ones most
   assign second_tick_o = sec_pulse;
   assign test_mux_output_o = r.tmux;
endmodule

// file: verif/rtcr_rate_comp_chk.sv
// port-level assertions for the rate trim and compensation block
`timescale 1ns/100ps
module rtcr_rate_comp_chk
   import rtcr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic crystal_tick_i,
   input wire logic [TEMP_W-1:0] die_temperature_result_i,
   input wire logic temp_done_i,
   input wire logic sleep_mode_i,
   input wire logic [TRIM_W-1:0] crystal_load_trim_o,
   input wire logic second_tick_o,
   input wire logic test_mux_output_o
);
   logic [13:0] q_idx;
   logic q_we;
   logic [TEMP_W-1:0] tcap;
   logic req;
   logic trim_wr;
   logic rd_ack;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign trim_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
      && wb_adr_i[15:2] == IDX_CRYSTAL_LOAD_TRIM;
   assign rd_ack = wb_ack_o && !q_we;
   // request address and last captured temperature
   always_ff @(posedge clk_i) begin
      if (req) begin
         q_idx <= wb_adr_i[15:2];
         q_we <= wb_we_i;
      end
      if (temp_done_i) begin
         tcap <= die_temperature_result_i;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   property p_ack_next;
      req |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_trim_wr;
      trim_wr |=> crystal_load_trim_o == $past(wb_dat_i[6:0]);
   endproperty
   a_trim_wr: assert property (p_trim_wr) else $error("trim not written");
   property p_trim_hold;
      !trim_wr |=> $stable(crystal_load_trim_o);
   endproperty
   a_trim_hold: assert property (p_trim_hold) else $error("trim changed without write");
   property p_trim_rst;
      $fell(rst_i) |-> crystal_load_trim_o == TRIM_RESET && !second_tick_o;
   endproperty
   a_trim_rst: assert property (p_trim_rst) else $error("bad state after reset");
   property p_tick;
      second_tick_o |=> !second_tick_o [*8];
   endproperty
   a_tick: assert property (p_tick) else $error("second tick too long");
   property p_temp_hi;
      rd_ack && q_idx == IDX_TEMP_HIGH && !$past(temp_done_i) |-> wb_dat_o[7:0] == tcap[10:3];
   endproperty
   a_temp_hi: assert property (p_temp_hi) else $error("temperature high byte wrong");
   property p_temp_lo;
      rd_ack && q_idx == IDX_TEMP_LOW && !$past(temp_done_i) |-> wb_dat_o[7:0] == {tcap[2:0], 5'h00};
   endproperty
   a_temp_lo: assert property (p_temp_lo) else $error("temperature low bits wrong");
   c_trim: cover property (trim_wr);
   c_second: cover property (second_tick_o);
   c_temp: cover property (temp_done_i && sleep_mode_i);
endmodule

// file: verif/tb.sv
// self-checking bench for the rate trim and compensation block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      err_count++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
   end \
end
module tb
   import rtcr_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic tick = 1'b1;
   logic tdone = 1'b0;
   logic sleep_mode = 1'b0;
   logic [3:0] sel = 4'h1;
   logic [15:0] adr = 16'h0000;
   logic [31:0] dat = 32'h00000000;
   logic [TEMP_W-1:0] temp = 11'h000;
   logic [31:0] rdat;
   logic ack;
   logic [TRIM_W-1:0] trim;
   logic sec;
   logic mux;
   int err_count = 0;
   int check_count = 0;
   int cyc_n = 0;
   rtcr_rate_comp rtcr_rate_comp_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .crystal_tick_i(tick), .die_temperature_result_i(temp), .temp_done_i(tdone),
      .sleep_mode_i(sleep_mode), .crystal_load_trim_o(trim), .second_tick_o(sec), .test_mux_output_o(mux)
   );
   always #25 clk_i = ~clk_i;
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 80000) begin
         err_count++;
         test_done;
      end
   end
   task automatic wb(input logic w, input logic [13:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {a, 2'b00};
      dat <= {24'h000000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      `CHK("ack", 1'b1, ack)
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [13:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      `CHK($sformatf("reg %h", a), e, q)
   endtask
   task automatic poll(input logic [13:0] a, input logic [7:0] m);
      logic [7:0] q;
      int n;
      n = 0;
      do begin
         wb(1'b0, a, 8'h00, q);
         n++;
      end while ((q & m) !== 8'h00 && n < 40);
      `CHK("busy bit", 8'h00, q & m)
   endtask
   task automatic pulse;
      @(posedge clk_i);
      tdone <= 1'b1;
      @(posedge clk_i);
      tdone <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic t_regs;
      rd(IDX_RATE_COARSE_TOP, {5'h00, COARSE_RESET[16:14]});
      rd(IDX_RATE_COARSE_MID, 8'h00);
      rd(IDX_RATE_COARSE_LOW_FINE, 8'h00);
      `CHK("trim", TRIM_RESET, trim)
      wr(IDX_CRYSTAL_LOAD_TRIM, 8'h7F);
      rd(IDX_CRYSTAL_LOAD_TRIM, 8'h7F);
      `CHK("trim", 7'h7F, trim)
      wr(IDX_CRYSTAL_LOAD_TRIM, {1'b0, TRIM_RESET});
      wr(14'h0001, 8'h5A);
      rd(14'h0001, 8'h00);
   endtask
   task automatic t_table;
      wr(IDX_TABLE_INDEX_CTRL, 8'hBE);
      wr(IDX_TABLE_BYTE, 8'h11);
      wr(IDX_TABLE_STROBES, 8'h01);
      poll(IDX_TABLE_STROBES, 8'h01);
      wr(IDX_TABLE_BYTE, 8'h80);
      wr(IDX_TABLE_STROBES, 8'h01);
      poll(IDX_TABLE_STROBES, 8'h01);
      rd(IDX_TABLE_INDEX_CTRL, 8'hC0);
      wr(IDX_TABLE_INDEX_CTRL, 8'h3E);
      wr(IDX_TABLE_STROBES, 8'h02);
      poll(IDX_TABLE_STROBES, 8'h02);
      rd(IDX_TABLE_BYTE, 8'h11);
      rd(IDX_TABLE_INDEX_CTRL, 8'h3E);
   endtask
   // entry 63 holds -128, reached by saturating the largest temperature
   task automatic t_comp;
      temp <= 11'h3FF;
      pulse;
      rd(IDX_RATE_COARSE_TOP, 8'h04);
      rd(IDX_TEMP_HIGH, 8'h7F);
      rd(IDX_TEMP_LOW, 8'hE0);
      wr(IDX_AUTO_COMP_ENABLE, 8'h20);
      sleep_mode <= 1'b1;
      pulse;
      rd(IDX_RATE_COARSE_TOP, 8'h03);
      rd(IDX_RATE_COARSE_MID, 8'hFF);
      rd(IDX_RATE_COARSE_LOW_FINE, 8'h80);
   endtask
   task automatic t_second;
      int n;
      n = 0;
      wr(IDX_TEST_MUX_SEL, {6'h00, TMUX_ONE_SECOND_TEST_PULSE});
      while (sec !== 1'b1 && n < 40000) begin
         @(posedge clk_i);
         n++;
      end
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
         if (n == 100) `CHK("pulse high", 1'b1, mux)
         if (n == 16000) `CHK("pulse low", 1'b0, mux)
      end while (sec !== 1'b1 && n < 40000);
      `CHK("ticks per second", (int'(PERIOD_NOMINAL) - 128) / 8, n)
      // third second of the four-second cycle: four-second pulse is low
      wr(IDX_TEST_MUX_SEL, {6'h00, TMUX_FOUR_SECOND_TEST_PULSE});
      repeat (2) @(posedge clk_i);
      `CHK("4s pulse", 1'b0, mux)
   endtask
   task automatic t_shadow;
      wr(IDX_SHADOW_CTRL, 8'h80);
      wr(IDX_RATE_COARSE_LOW_FINE, 8'h01);
      rd(IDX_SHADOW_CTRL, 8'h80);
      wr(IDX_SHADOW_CTRL, 8'h00);
      poll(IDX_SHADOW_CTRL, 8'h80);
      rd(IDX_RATE_COARSE_LOW_FINE, 8'h01);
      rd(IDX_RATE_COARSE_MID, 8'hFF);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_table;
      t_comp;
      t_second;
      t_shadow;
      test_done;
   end
endmodule
bind rtcr_rate_comp rtcr_rate_comp_chk rtcr_rate_comp_chk_i (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .crystal_tick_i(crystal_tick_i), .die_temperature_result_i(die_temperature_result_i),
   .temp_done_i(temp_done_i), .sleep_mode_i(sleep_mode_i), .crystal_load_trim_o(crystal_load_trim_o),
   .second_tick_o(second_tick_o), .test_mux_output_o(test_mux_output_o)
);
